// ---- inc/ltpg_map.vh ----
// Register map, field positions and reset values of the lane test pattern generator.
// Assumes byte addresses on a 32-bit APB bus; one aligned word per register.
`ifndef LTPG_MAP_VH
`define LTPG_MAP_VH

`define LTPG_LANE0_CTL_OFF 20'h1e020
`define LTPG_LANE1_CTL_OFF 20'h1e060
`define LTPG_LANE_STRIDE 20'h00040
`define LTPG_MACRO_STRIDE 20'h00200
`define LTPG_CTL_RESET 32'h0000_0000

// Fields, numbered with bit 0 as the least significant bit of the bus word.
`define LTPG_MODE_LSB 0
`define LTPG_MODE_MSB 2
`define LTPG_TRIG_BIT 3
`define LTPG_PAT_LSB 4
`define LTPG_PAT_MSB 13

`define LTPG_MODE_OFF 3'h0
`define LTPG_MODE_LFSR15 3'h1
`define LTPG_MODE_LFSR7 3'h2
`define LTPG_MODE_FIXED 3'h3
`define LTPG_MODE_DCBAL 3'h4
`define LTPG_MODE_QUAD 3'h5

`define LTPG_LFSR_SEED 15'h0001
`define LTPG_ALL_ONES 10'h3ff

`endif

// ---- rtl/ltpg_top.v ----
// Lane test pattern generator of one transceiver macro: APB control registers,
// per-lane word generators and a per-lane output FIFO.
// Assumes the PLL power-on flag comes straight from the PLL, outside the pclk domain.
//
// The implementer's own choice: the APB register port.
`include "ltpg_map.vh"

module ltpg_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Fill side.
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side.
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Pointers wrap on their own, so DEPTH must be two to the power AW.
  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_q];

  always @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_inc(rd_ptr_q);
      end
    end
  end

  // Count carries one bit more than the pointers so that full and empty differ.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= {(AW+1){1'b0}};
    end else if (push && !pop) begin
      count_q <= count_q + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      count_q <= count_q - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // ltpg_fifo

// Summary of operation
// - Each lane's register sits 0x40 above the previous lane's.
// - Register contents only mean something once the transceiver is initialized.
// - Initialized means the PLL power-on flag is 1.
// - Mode 3 sends the programmed word on every slot.
// - Mode 4 alternates programmed word and its complement.
// - Mode 5 cycles zeros, word, all ones, complement.
// - Pattern field holds 10 bits, used only by modes 3 to 5.
// - Error trigger flips the LSB of one generated word.
// - Reset clears pattern, trigger and mode; reserved bits read zero.
// - Lane 1 control decoded at 1E060 plus macro offset, lane 0 0x40 below.
module ltpg_top #(
  parameter ADDR_W = 20,
  parameter MACRO = 0,
  parameter NUM_LANES = 4,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // APB slave.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Transceiver status.
  input wire pll_power_on_flag,
  output wire xcvr_ready,
  // Transmit words, one 10-bit lane per slice.
  output wire [NUM_LANES-1:0] tx_valid,
  input wire [NUM_LANES-1:0] tx_ready,
  output wire [10*NUM_LANES-1:0] tx_word
);
  // Lane 0 of this macro; every later lane sits one stride above the one before.
  localparam [31:0] LANE0_BASE = `LTPG_LANE0_CTL_OFF + MACRO * `LTPG_MACRO_STRIDE;

  // Returns the lane index in the low bits and a hit flag on top.
  function [8:0] lane_decode;
    input [ADDR_W-1:0] addr;
    integer i;
    reg [31:0] lane_addr;
    begin
      lane_decode = 9'h000;
      lane_addr = LANE0_BASE;
      for (i = 0; i < NUM_LANES; i = i + 1) begin
        // Only the bus width of the address takes part in the compare.
        if (addr == lane_addr[ADDR_W-1:0]) begin
          lane_decode = {1'b1, i[7:0]};
        end
        lane_addr = lane_addr + `LTPG_LANE_STRIDE;
      end
    end
  endfunction

  // True for the codes that produce words; 0 is off and 6 and 7 are reserved.
  function mode_live_f;
    input [2:0] m;
    begin
      mode_live_f = (m >= `LTPG_MODE_LFSR15) && (m <= `LTPG_MODE_QUAD);
    end
  endfunction

  // Steps the LFSR ten times and returns the next state above the 10-bit word.
  function [24:0] lfsr_step;
    input [14:0] s_in;
    input short_poly;
    integer k;
    reg [14:0] s;
    reg [9:0] w;
    reg fb;
    begin
      s = s_in;
      w = 10'h000;
      fb = 1'b0;
      for (k = 0; k < 10; k = k + 1) begin
        fb = short_poly ? (s[6] ^ s[5]) : (s[14] ^ s[13]);
        w = {w[8:0], fb};
        s = {s[13:0], fb};
      end
      lfsr_step = {s, w};
    end
  endfunction

  reg sync1_q;
  reg sync2_q;
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  wire [8:0] dec = lane_decode(paddr);
  wire hit = dec[8];
  wire wr_en = psel && penable && pwrite && hit;
  wire [32*NUM_LANES-1:0] ctl_rd;

  // The flag is asynchronous to pclk, so it is synchronised before use.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pll_power_on_flag;
      sync2_q <= sync1_q;
    end
  end
  assign xcvr_ready = sync2_q;

  // Read data is captured in the setup cycle so the access phase needs no wait.
  // Before the PLL is up the register contents are not trusted, so reads return zero.
  always @* begin
    prdata_d = prdata_q;
    if (psel && !penable) begin
      if (hit && sync2_q) begin
        prdata_d = ctl_rd[32*dec[7:0] +: 32];
      end else begin
        prdata_d = `LTPG_CTL_RESET;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `LTPG_CTL_RESET;
    end else begin
      prdata_q <= prdata_d;
    end
  end
  assign prdata = prdata_q;
  assign pready = 1'b1;
  // Unmapped offsets are refused rather than aliased onto a lane.
  assign pslverr = psel && penable && !hit;

  genvar l;
  generate
    for (l = 0; l < NUM_LANES; l = l + 1) begin : g_lane
      reg [9:0] pat_q;
      reg [2:0] mode_q;
      reg trig_q;
      reg [2:0] run_mode_q;
      reg [1:0] phase_q;
      reg [14:0] lfsr_q;
      reg [9:0] word_d;
      wire lane_wr = wr_en && (dec[7:0] == l);
      wire short_poly = (mode_q == `LTPG_MODE_LFSR7);
      wire [24:0] lfsr_nx = lfsr_step(lfsr_q, short_poly);
      wire mode_live = mode_live_f(mode_q);
      wire settled = (run_mode_q == mode_q);
      wire fifo_in_ready;
      // Words are produced only after init, and back-pressure stalls the generator.
      wire gen_push = sync2_q && mode_live && settled && fifo_in_ready;

      always @* begin
        case (mode_q)
          `LTPG_MODE_LFSR15: word_d = lfsr_nx[9:0];
          `LTPG_MODE_LFSR7: word_d = lfsr_nx[9:0];
          `LTPG_MODE_FIXED: word_d = pat_q;
          `LTPG_MODE_DCBAL: word_d = phase_q[0] ? ~pat_q : pat_q;
          `LTPG_MODE_QUAD: begin
            case (phase_q)
              2'h0: word_d = 10'h000;
              2'h1: word_d = pat_q;
              2'h2: word_d = `LTPG_ALL_ONES;
              default: word_d = ~pat_q;
            endcase
          end
          default: word_d = 10'h000;
        endcase
      end

      // Control register of this lane.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pat_q <= 10'h000;
          mode_q <= `LTPG_MODE_OFF;
        end else if (lane_wr) begin
          pat_q <= pwdata[`LTPG_PAT_MSB:`LTPG_PAT_LSB];
          mode_q <= pwdata[`LTPG_MODE_MSB:`LTPG_MODE_LSB];
        end
      end

      // A write that sets the trigger wins over the clear from a sent word.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          trig_q <= 1'b0;
        end else if (lane_wr) begin
          trig_q <= pwdata[`LTPG_TRIG_BIT];
        end else if (gen_push) begin
          trig_q <= 1'b0;
        end
      end

      // A new mode restarts the sequence, so each mode opens from a known word.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          run_mode_q <= `LTPG_MODE_OFF;
          phase_q <= 2'h0;
          lfsr_q <= `LTPG_LFSR_SEED;
        end else if (!settled) begin
          run_mode_q <= mode_q;
          phase_q <= 2'h0;
          lfsr_q <= `LTPG_LFSR_SEED;
        end else if (gen_push) begin
          phase_q <= phase_q + 2'h1;
          lfsr_q <= lfsr_nx[24:10];
        end
      end

      // Reserved bits are tied to zero so software never sees stale state there.
      assign ctl_rd[32*l +: 32] = {18'h00000, pat_q, trig_q, mode_q};
      wire [9:0] tx_in = word_d ^ {9'h000, trig_q};

      ltpg_fifo #(
        .WIDTH(10),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
      ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(gen_push),
        .in_ready(fifo_in_ready),
        .in_data(tx_in),
        .out_valid(tx_valid[l]),
        .out_ready(tx_ready[l]),
        .out_data(tx_word[10*l +: 10])
      );
    end
  endgenerate
endmodule // ltpg_top

// ---- dv/ltpg_chk.sv ----
// Concurrent checks on the ports of the pattern generator top.
// Assumes one pclk domain with presetn as its asynchronous reset.
module ltpg_chk #(
  parameter ADDR_W = 20,
  parameter MACRO = 0
) (
  // APB.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Status and stream.
  input wire pll_power_on_flag,
  input wire xcvr_ready,
  input wire [3:0] tx_valid,
  input wire [3:0] tx_ready,
  input wire [39:0] tx_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire hit = paddr[19:8] == 12'h1e0 + 2 * MACRO && paddr[5:0] == 6'h20;
  property p_map; acc && !hit |-> pslverr; endproperty
  a_map: assert property (p_map) else $error("unmapped access not refused");
  property p_hit; acc && hit |-> !pslverr; endproperty
  a_hit: assert property (p_hit) else $error("lane register refused");
  property p_rsv; acc && !pwrite |-> prdata[31:14] == 18'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_init; acc && !pwrite && !xcvr_ready |-> prdata == 32'h0; endproperty
  a_init: assert property (p_init) else $error("read before init not zero");
  property p_sync; $rose(xcvr_ready) |-> $past(pll_power_on_flag, 2); endproperty
  a_sync: assert property (p_sync) else $error("ready without pll flag");
  property p_hold; tx_valid[0] && !tx_ready[0] |=> tx_valid[0] && $stable(tx_word[9:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("word lost under stall");
  property p_gen; $rose(tx_valid[0]) |-> $past(xcvr_ready); endproperty
  a_gen: assert property (p_gen) else $error("word made before init");
  property p_off; !xcvr_ready [*3] |-> tx_valid == 4'h0; endproperty
  a_off: assert property (p_off) else $error("stream while not ready");
  cover property (acc && !hit);
  cover property (tx_valid[0] && !tx_ready[0]);
  cover property ($rose(xcvr_ready));
endmodule // ltpg_chk

bind ltpg_top ltpg_chk #(.ADDR_W(ADDR_W), .MACRO(MACRO)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pll_power_on_flag(pll_power_on_flag), .xcvr_ready(xcvr_ready), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_word(tx_word));

// ---- dv/ltpg_sink.sv ----
// Lane transmitter model: takes words while not stalled, keeps lane 0 words.
// Assumes the bench drives stall just after a rising edge.
module ltpg_sink (
  // Clock.
  input wire logic pclk,
  // Stream.
  input wire logic [3:0] tx_valid,
  output logic [3:0] tx_ready,
  input wire logic [39:0] tx_word,
  // Flow control.
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] got[$];
  assign tx_ready = {4{~stall}};
  always @(posedge pclk) begin
    if (tx_valid[0] && tx_ready[0]) got.push_back(tx_word[9:0]);
  end
endmodule // ltpg_sink

// ---- dv/tb_lane_test_pattern_generator.sv ----
// Self-checking bench for the lane test pattern generator top.
// Assumes macro 0 and the lane transmitter model on all four lanes.
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_lane_test_pattern_generator;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, flag = 0, stall = 1, err;
  logic [19:0] paddr = 20'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, xcvr_ready;
  logic [3:0] tx_valid, tx_ready;
  logic [39:0] tx_word;
  logic [2:0] m;
  logic [31:0] ctl [8] = '{32'h2a53, 32'h0f04, 32'h1555, 32'h1, 32'h2, 32'h3ff0, 32'h16, 32'h17};
  logic [39:0] ex [8];
  int miscompares = 0, num_checks = 0;
  ltpg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pll_power_on_flag(flag), .xcvr_ready(xcvr_ready),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word));
  ltpg_sink sink (.pclk(pclk), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
    .stall(stall));
  initial begin
    forever #50 pclk = ~pclk;
  end
  function automatic logic [39:0] lfsr4(bit s7);
    logic [14:0] s = 15'h0001;
    logic [39:0] r;
    logic fb;
    for (int i = 0; i < 40; i++) begin
      fb = s7 ? s[6] ^ s[5] : s[14] ^ s[13];
      s = {s[13:0], fb};
      r[39-i] = fb;
    end
    return r;
  endfunction
  task automatic final_report();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin miscompares++; final_report(); end
  endtask
  // Let the generator fill the buffer under stall, stop it, then drain.
  task automatic run(input logic [31:0] v);
    stall <= 1'b1;
    apb(1, 20'h1e020, v);
    repeat (25) @(posedge pclk);
    apb(0, 20'h1e020, 32'h0);
    apb(1, 20'h1e020, 32'h0);
    sink.got.delete();
    stall <= 1'b0;
    repeat (25) @(posedge pclk);
  endtask
  initial begin
    ex = '{{4{10'h2a5}}, {2{10'h0f0, 10'h30f}}, {10'h0, 10'h155, 10'h3ff, 10'h2aa},
      lfsr4(0), lfsr4(1), 40'h0, 40'h0, 40'h0};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, 20'h1e020, 32'h2a53);
    apb(0, 20'h1e020, 32'h0);
    `CHK("pre_init", 32'h0, rd)
    flag <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("xcvr_ready", 1'b1, xcvr_ready)
    for (int i = 0; i < 8; i++) begin
      m = ctl[i][2:0];
      stall <= 1'b1;
      apb(1, 20'h1e020, 32'hffffc000 | ctl[i]);
      apb(0, 20'h1e020, 32'h0);
      `CHK("ctl_read", ctl[i], rd)
      run(ctl[i]);
      `CHK("count", (m > 0 && m < 6) ? 16 : 0, sink.got.size())
      for (int k = 0; k < 4 && m > 0 && m < 6; k++)
        `CHK("word", ex[i][39-10*k -: 10], sink.got[k])
    end
    run(32'h200b);
    `CHK("err_word", 10'h201, sink.got[0])
    `CHK("next_word", 10'h200, sink.got[1])
    // Only the addressed lane may stream; the others stay silent.
    stall <= 1'b1;
    apb(1, 20'h1e0e0, 32'h1553);
    repeat (20) @(posedge pclk);
    `CHK("lane3_word", {1'b1, 10'h155}, {tx_valid[3], tx_word[39:30]})
    `CHK("lane_quiet", 3'h0, tx_valid[2:0])
    apb(1, 20'h1e0e0, 32'h0);
    stall <= 1'b0;
    repeat (20) @(posedge pclk);
    `CHK("lane3_drained", 4'h0, tx_valid)
    for (int l = 0; l < 4; l++) apb(1, 20'h1e020 + 20'h40 * l, 32'h10 * (l + 1));
    for (int l = 0; l < 4; l++) begin
      apb(0, 20'h1e020 + 20'h40 * l, 32'h0);
      `CHK("lane", 32'h10 * (l + 1), rd)
    end
    apb(1, 20'h1e024, 32'hffff);
    `CHK("unmapped", 1'b1, err)
    // Power the port down for longer than the required wait before bringing it back.
    flag <= 1'b0;
    repeat (110) @(posedge pclk);
    `CHK("powered_down", 1'b0, xcvr_ready)
    apb(0, 20'h1e060, 32'h0);
    `CHK("read_down", 32'h0, rd)
    flag <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, 20'h1e060, 32'h0);
    `CHK("read_up", 32'h20, rd)
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, 20'h1e060, 32'h0);
    `CHK("after_reset", 32'h0, rd)
    final_report();
  end
endmodule // tb_lane_test_pattern_generator
